//--- common/wdn_pkg.sv
// Shared constants and carrier types for the slow-clock watchdog.
// Assumes a single 20 MHz system clock and an 8-bit register port.
package wdn_pkg;

  // System clock
  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned CLK_PERIOD_NS  = 50;

  // Slow oscillator and timeout window
  localparam int unsigned SLOW_HZ        = 32_768;
  localparam int unsigned TIMEOUT_MS     = 3_500;
  localparam int unsigned MS_PER_S       = 1_000;
  localparam int unsigned TIMEOUT_TICKS  = (TIMEOUT_MS * SLOW_HZ) / MS_PER_S;
  localparam int unsigned COUNT_W        = 17;

  // Register addresses
  localparam logic [23:0] CTL_ADDR       = 24'h00_FF40;
  localparam logic [23:0] STAT_ADDR      = 24'h00_FF48;
  localparam logic [23:0] MASK_ADDR      = 24'h00_FF49;
  localparam logic [23:0] COUNT_ADDR     = 24'h00_FF4A;
  localparam logic [23:0] FLAG_ADDR      = 24'h00_FF4B;

  // Field positions
  localparam int unsigned RESTART_BIT    = 2;
  localparam int unsigned EV_TIMEOUT     = 0;
  localparam int unsigned EV_RESTART     = 1;
  localparam int unsigned EV_W           = 2;
  localparam int unsigned COUNT_HI_LSB   = 9;
  localparam int unsigned FLAG_NMI       = 0;
  localparam int unsigned FLAG_SLEEP     = 1;

  // Reset values
  localparam logic [7:0]  RDATA_RESET    = 8'h00;
  localparam logic [1:0]  EV_RESET       = 2'h0;

  // Exception parameters toward the CPU core
  localparam logic [2:0]  NMI_LEVEL      = 3'h4;
  localparam logic [23:0] NMI_VECTOR     = 24'h00_0004;

  typedef struct packed {
    logic [23:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } wdn_bus_req_t;

endpackage

//--- rtl/wdn_pin_sync.sv
// Three-stage synchroniser with agreement filter for a pin input.
// Assumes the pin changes far slower than clock_i.
`timescale 1ns/1ps
module wdn_pin_sync (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic reset_i,
  // Pin side
  input  wire logic pin_i,
  // Filtered outputs
  output logic      level_o,
  output logic      rise_o
);

  logic meta;
  logic stage2;
  logic stage3;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      meta   <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      meta   <= pin_i;
      stage2 <= meta;
      stage3 <= stage2;
    end
  end

  // Level moves only when stages two and three agree
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      level_o <= 1'b0;
      rise_o  <= 1'b0;
    end else begin
      rise_o <= 1'b0;
      if (stage2 == stage3) begin
        level_o <= stage3;
        rise_o  <= stage3 & ~level_o;
      end
    end
  end

endmodule // wdn_pin_sync

//--- rtl/wdn_watchdog.sv
// Watchdog timer counting slow-oscillator periods and raising an NMI request.
// Assumes the CPU core takes the NMI, and sleep state arrives as a level.
//
// Notes on behaviour
// [R1] Counter advances only on slow oscillator edges, never on the system clock.
// [R2] No restart for the timeout window raises the NMI request.
// [R3] Halt does not stop counting, so a long halt still gives the NMI.
// [R4] Sleep state freezes the counter where it stands.
// [R5] NMI goes to the unmaskable level-4 input of the CPU.
// [R6] The exception vector presented with the NMI is 000004H.
// [R7] Writing one to the restart bit clears the counter; counting resumes at once.
// [R8] Writing zero there does nothing; the bit always reads zero.
// [R9] Software restarts the watchdog within every three seconds.
// [R10] Software avoids the sleep instruction for 2 ms after an NMI.
// [R11] Reset clears the counter so the first window starts at release.
`timescale 1ns/1ps
module wdn_watchdog #(
  parameter int unsigned TIMEOUT_TICKS = wdn_pkg::TIMEOUT_TICKS
) (
  // Clock and reset
  input  wire logic                  clock_i,
  input  wire logic                  reset_i,
  // Register port
  input  wire wdn_pkg::wdn_bus_req_t bus_i,
  output logic [7:0]                 rdata_o,
  // Slow clock and power state
  input  wire logic                  low_speed_oscillator_i,
  input  wire logic                  sleep_instruction_active_i,
  // CPU exception side
  output logic                       nmi_request_o,
  output logic [2:0]                 nmi_level_o,
  output logic [23:0]                nmi_vector_o,
  // Status interrupt
  output logic                       irq_o
);

  localparam int unsigned CW = wdn_pkg::COUNT_W;
  localparam logic [CW-1:0] LIMIT    = CW'(TIMEOUT_TICKS);
  localparam logic [CW-1:0] LIMIT_M1 = CW'(TIMEOUT_TICKS - 1);

  logic                          slow_tick;
  logic [CW-1:0]                 count;
  logic [wdn_pkg::EV_W-1:0]      status;
  logic [wdn_pkg::EV_W-1:0]      mask;
  logic [wdn_pkg::EV_W-1:0]      ev_set;
  logic [wdn_pkg::EV_W-1:0]      ev_clr;
  logic                          ctl_hit;
  logic                          stat_hit;
  logic                          mask_hit;
  logic                          restart_wr;
  logic                          advance;
  logic                          expire;

  // The oscillator is an asynchronous pin; only its filtered rising edge is used
  wdn_pin_sync u_osc_sync (
    .clock_i (clock_i),
    .reset_i (reset_i),
    .pin_i   (low_speed_oscillator_i),
    .level_o (),
    .rise_o  (slow_tick)
  );

  // Address decode
  assign ctl_hit    = (bus_i.addr == wdn_pkg::CTL_ADDR);
  assign stat_hit   = (bus_i.addr == wdn_pkg::STAT_ADDR);
  assign mask_hit   = (bus_i.addr == wdn_pkg::MASK_ADDR);
  assign restart_wr = bus_i.wr & ctl_hit & bus_i.wdata[wdn_pkg::RESTART_BIT]; // [R7] [R8]

  // Halt has no input here on purpose: the count runs through it
  assign advance = slow_tick & ~sleep_instruction_active_i & (count != LIMIT); // [R1] [R3] [R4]
  assign expire  = advance & (count == LIMIT_M1) & ~restart_wr;               // [R2]

  // Watchdog counter; saturates at the limit until restarted
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      count <= '0; // [R11]
    end else if (restart_wr) begin
      count <= '0; // [R7]
    end else if (advance) begin
      count <= count + 1'b1; // [R1]
    end
  end

  // NMI request stays high until software restarts the watchdog
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      nmi_request_o <= 1'b0;
    end else if (restart_wr) begin
      nmi_request_o <= 1'b0;
    end else if (expire) begin
      nmi_request_o <= 1'b1; // [R2] [R3]
    end
  end

  // Fixed exception level and vector, held in flops so outputs stay registered
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      nmi_level_o  <= wdn_pkg::NMI_LEVEL;  // [R5]
      nmi_vector_o <= wdn_pkg::NMI_VECTOR; // [R6]
    end else begin
      nmi_level_o  <= wdn_pkg::NMI_LEVEL;
      nmi_vector_o <= wdn_pkg::NMI_VECTOR;
    end
  end

  // Sticky events; a new event in the clearing cycle survives the clear
  always_comb begin
    ev_set = '0;
    ev_set[wdn_pkg::EV_TIMEOUT] = expire;
    ev_set[wdn_pkg::EV_RESTART] = restart_wr;
    ev_clr = '0;
    if (bus_i.wr && stat_hit) begin
      ev_clr = bus_i.wdata[wdn_pkg::EV_W-1:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      status <= wdn_pkg::EV_RESET;
    end else begin
      status <= (status & ~ev_clr) | ev_set;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      mask <= wdn_pkg::EV_RESET;
    end else if (bus_i.wr && mask_hit) begin
      mask <= bus_i.wdata[wdn_pkg::EV_W-1:0];
    end
  end

  // Status interrupt is separate from the NMI, which no mask can block
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status & mask);
    end
  end

  // Read data stand for exactly one cycle after the read strobe
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rdata_o <= wdn_pkg::RDATA_RESET;
    end else begin
      rdata_o <= wdn_pkg::RDATA_RESET;
      if (bus_i.rd) begin
        case (bus_i.addr)
          wdn_pkg::CTL_ADDR: begin
            rdata_o <= 8'h00; // [R8]
          end
          wdn_pkg::STAT_ADDR: begin
            rdata_o <= {6'h00, status};
          end
          wdn_pkg::MASK_ADDR: begin
            rdata_o <= {6'h00, mask};
          end
          wdn_pkg::COUNT_ADDR: begin
            rdata_o <= count[CW-1:wdn_pkg::COUNT_HI_LSB];
          end
          wdn_pkg::FLAG_ADDR: begin
            rdata_o[wdn_pkg::FLAG_NMI]   <= nmi_request_o;
            rdata_o[wdn_pkg::FLAG_SLEEP] <= sleep_instruction_active_i;
          end
          default: begin
            rdata_o <= wdn_pkg::RDATA_RESET;
          end
        endcase
      end
    end
  end

  // Checks
  sequence s_restart_write;
    bus_i.wr && ctl_hit && bus_i.wdata[wdn_pkg::RESTART_BIT];
  endsequence

  sequence s_counter_cleared;
    (count == '0) && !nmi_request_o;
  endsequence

  sequence s_last_tick;
    slow_tick && !sleep_instruction_active_i && (count == LIMIT_M1) && !restart_wr;
  endsequence

  chk_slow_edge_only: assert property ( // [R1]
    @(posedge clock_i) disable iff (reset_i)
    (count != $past(count)) |-> ($past(slow_tick) || $past(restart_wr)))
    else $error("counter moved without a slow tick or restart");

  chk_timeout_raises: assert property ( // [R2]
    @(posedge clock_i) disable iff (reset_i)
    s_last_tick |=> nmi_request_o && (count == LIMIT))
    else $error("timeout did not raise the NMI request");

  chk_nmi_tracks_limit: assert property ( // [R2]
    @(posedge clock_i) disable iff (reset_i)
    nmi_request_o == (count == LIMIT))
    else $error("NMI request and saturated count disagree");

  chk_halt_keeps_counting: assert property ( // [R3]
    @(posedge clock_i) disable iff (reset_i)
    (slow_tick && !sleep_instruction_active_i && !restart_wr && (count != LIMIT))
      |=> (count == $past(count) + 1'b1))
    else $error("counter failed to advance on an awake slow tick");

  chk_sleep_freezes: assert property ( // [R4]
    @(posedge clock_i) disable iff (reset_i)
    (sleep_instruction_active_i && !restart_wr) |=> (count == $past(count)))
    else $error("counter moved during sleep");

  chk_nmi_level_four: assert property ( // [R5]
    @(posedge clock_i) disable iff (reset_i)
    nmi_request_o |-> (nmi_level_o == 3'h4))
    else $error("NMI level is not four");

  chk_nmi_vector_addr: assert property ( // [R6]
    @(posedge clock_i) disable iff (reset_i)
    nmi_request_o |-> (nmi_vector_o == 24'h00_0004))
    else $error("NMI vector is not 000004H");

  chk_restart_clears: assert property ( // [R7]
    @(posedge clock_i) disable iff (reset_i)
    s_restart_write |=> s_counter_cleared)
    else $error("restart write did not clear the counter");

  chk_restart_resumes: assert property ( // [R7]
    @(posedge clock_i) disable iff (reset_i)
    s_restart_write ##1 (slow_tick && !sleep_instruction_active_i && !restart_wr)
      |=> (count == 17'h0_0001))
    else $error("counting did not resume after restart");

  chk_zero_write_noop: assert property ( // [R8]
    @(posedge clock_i) disable iff (reset_i)
    (bus_i.wr && ctl_hit && !bus_i.wdata[wdn_pkg::RESTART_BIT] && !slow_tick)
      |=> (count == $past(count)))
    else $error("zero write to restart bit changed the counter");

  chk_restart_reads_zero: assert property ( // [R8]
    @(posedge clock_i) disable iff (reset_i)
    (bus_i.rd && ctl_hit) |=> (rdata_o[wdn_pkg::RESTART_BIT] == 1'b0))
    else $error("restart bit read back as one");

  chk_reset_clears: assert property ( // [R11]
    @(posedge clock_i)
    reset_i |=> (count == '0) && !nmi_request_o)
    else $error("reset left the counter running");

  chk_event_set_wins: assert property ( // [R2]
    @(posedge clock_i) disable iff (reset_i)
    expire |=> status[wdn_pkg::EV_TIMEOUT])
    else $error("timeout event lost");

  // A raised request must survive until software restarts the watchdog
  sequence s_nmi_unserved;
    nmi_request_o && !restart_wr;
  endsequence

  sequence s_timeout_clear;
    bus_i.wr && stat_hit && bus_i.wdata[wdn_pkg::EV_TIMEOUT] && !expire;
  endsequence

  chk_nmi_holds: assert property ( // [R2]
    @(posedge clock_i) disable iff (reset_i)
    s_nmi_unserved |=> nmi_request_o)
    else $error("NMI request dropped without a restart");

  chk_nmi_rise_cause: assert property ( // [R2]
    @(posedge clock_i) disable iff (reset_i)
    $rose(nmi_request_o) |-> ($past(count) == LIMIT_M1))
    else $error("NMI request rose before the window ran out");

  chk_count_saturates: assert property ( // [R2]
    @(posedge clock_i) disable iff (reset_i)
    ((count == LIMIT) && !restart_wr) |=> (count == LIMIT))
    else $error("counter left the limit without a restart");

  chk_tick_is_pulse: assert property ( // [R1]
    @(posedge clock_i) disable iff (reset_i)
    slow_tick |=> !slow_tick)
    else $error("slow tick lasted more than one cycle");

  chk_sleep_no_nmi: assert property ( // [R4]
    @(posedge clock_i) disable iff (reset_i)
    (sleep_instruction_active_i && !nmi_request_o) |=> !nmi_request_o)
    else $error("NMI request raised during sleep");

  chk_mask_not_nmi: assert property ( // [R5]
    @(posedge clock_i) disable iff (reset_i)
    (expire && (mask == '0)) |=> nmi_request_o)
    else $error("status mask blocked the NMI request");

  chk_status_clear: assert property (
    @(posedge clock_i) disable iff (reset_i)
    s_timeout_clear |=> !status[wdn_pkg::EV_TIMEOUT])
    else $error("writing one did not clear the timeout event");

  chk_irq_follows: assert property (
    @(posedge clock_i) disable iff (reset_i)
    irq_o == $past(|(status & mask)))
    else $error("status interrupt does not follow the masked status");

  chk_read_stands_once: assert property (
    @(posedge clock_i) disable iff (reset_i)
    !$past(bus_i.rd) |-> (rdata_o == wdn_pkg::RDATA_RESET))
    else $error("read data stood outside the cycle after a read");

  chk_count_read_high: assert property (
    @(posedge clock_i) disable iff (reset_i)
    (bus_i.rd && (bus_i.addr == wdn_pkg::COUNT_ADDR))
      |=> (rdata_o == $past(count[CW-1:wdn_pkg::COUNT_HI_LSB])))
    else $error("count register read back the wrong bits");

endmodule // wdn_watchdog

//--- testbench/wdn_cpu_model.sv
// CPU core model: takes the watchdog NMI and holds off sleep after it.
// Assumes the watchdog outputs are registered on clock_i.
`timescale 1ns/1ps
module wdn_cpu_model #(
  parameter int HOLD_CYC = 1049
) (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  // Watchdog side
  input  wire logic        nmi_i,
  input  wire logic [2:0]  level_i,
  input  wire logic [23:0] vector_i,
  // Software side
  input  wire logic        sleep_req_i,
  output logic             sleep_o,
  output logic [23:0]      vec_o,
  output logic [2:0]       lvl_o
);
  logic nmi_d;
  int   hold;

  // Sleep is withheld for a while after an NMI
  assign sleep_o = sleep_req_i && (hold == 0);

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      nmi_d <= 1'b0;
      hold  <= 0;
      vec_o <= 24'h00_0000;
      lvl_o <= 3'h0;
    end else begin
      nmi_d <= nmi_i;
      if (nmi_i && !nmi_d) begin
        // Exception entry latches level and vector
        vec_o <= vector_i;
        lvl_o <= level_i;
        hold  <= HOLD_CYC;
      end else if (hold != 0) begin
        hold <= hold - 1;
      end
    end
  end
endmodule // wdn_cpu_model

//--- testbench/wdn_watchdog_tb.sv
// Self-checking bench for the watchdog with a CPU model on the NMI side.
// Assumes a shortened timeout and a slow clock of 16 system clocks.
`timescale 1ns/1ps
module wdn_watchdog_tb;
  localparam int TICKS = 20;
  localparam int HALF  = 8;
  localparam int TCLK  = 2 * HALF;
  localparam int LIMIT = 20000;

  logic                  clock_i    = 1'b0;
  logic                  reset_i    = 1'b1;
  logic                  osc        = 1'b0;
  logic                  sleep_req  = 1'b0;
  wdn_pkg::wdn_bus_req_t bus        = '0;
  logic [7:0]            rdata_o;
  logic                  sleep;
  logic                  nmi_request_o;
  logic [2:0]            nmi_level_o;
  logic [23:0]           nmi_vector_o;
  logic                  irq_o;
  logic [23:0]           vec_seen;
  logic [2:0]            lvl_seen;
  int                    cyc        = 0;
  int                    ocnt       = 0;
  int                    rel        = 0;
  int                    n_fail     = 0;
  int                    num_checks = 0;

  wdn_watchdog #(.TIMEOUT_TICKS(TICKS)) DUT (
    .clock_i(clock_i), .reset_i(reset_i), .bus_i(bus), .rdata_o(rdata_o),
    .low_speed_oscillator_i(osc), .sleep_instruction_active_i(sleep),
    .nmi_request_o(nmi_request_o), .nmi_level_o(nmi_level_o),
    .nmi_vector_o(nmi_vector_o), .irq_o(irq_o));

  wdn_cpu_model #(.HOLD_CYC(64)) cpu (
    .clock_i(clock_i), .reset_i(reset_i), .nmi_i(nmi_request_o),
    .level_i(nmi_level_o), .vector_i(nmi_vector_o), .sleep_req_i(sleep_req),
    .sleep_o(sleep), .vec_o(vec_seen), .lvl_o(lvl_seen));

  always #25 clock_i = ~clock_i;

  // Slow oscillator runs free, also in sleep, so a frozen counter shows
  always @(posedge clock_i) begin
    cyc  <= cyc + 1;
    ocnt <= (ocnt == HALF - 1) ? 0 : ocnt + 1;
    if (ocnt == HALF - 1) begin
      osc <= ~osc;
    end
    if (cyc == LIMIT) begin
      n_fail = n_fail + 1;
      test_done();
    end
  end

  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [23:0] a, input logic [7:0] d);
    @(posedge clock_i);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock_i);
    bus.wr <= 1'b0;
    #1;
  endtask

  task automatic rchk(input string nm, input logic [23:0] a, input logic [7:0] exp);
    @(posedge clock_i);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock_i);
    bus.rd <= 1'b0;
    #1;
    chk(nm, {16'h0000, exp}, {16'h0000, rdata_o});
  endtask

  // Waits for the NMI and checks it came 19 to 21 slow periods after t0
  task automatic twait(input string nm, input int t0);
    int n;
    n = 0;
    while (nmi_request_o !== 1'b1 && n < 1000) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    chk(nm, 24'h00_0001, {23'h0, (cyc - t0 >= 19 * TCLK) && (cyc - t0 <= 21 * TCLK)});
  endtask

  task automatic t_reset();
    chk("level", 24'h00_0004, {21'h0, nmi_level_o});
    chk("vector", 24'h00_0004, nmi_vector_o);
    rchk("status", wdn_pkg::STAT_ADDR, 8'h00);
    rchk("flags", wdn_pkg::FLAG_ADDR, 8'h00);
    $display("done reset");
  endtask

  task automatic t_timeout();
    twait("nmi after reset", rel);
    rchk("status", wdn_pkg::STAT_ADDR, 8'h01);
    rchk("flags", wdn_pkg::FLAG_ADDR, 8'h01);
    chk("cpu vector", 24'h00_0004, vec_seen);
    chk("cpu level", 24'h00_0004, {21'h0, lvl_seen});
    $display("done timeout");
  endtask

  task automatic t_restart();
    wr(wdn_pkg::CTL_ADDR, 8'hFB);
    chk("nmi kept", 24'h00_0001, {23'h0, nmi_request_o});
    rchk("control", wdn_pkg::CTL_ADDR, 8'h00);
    wr(wdn_pkg::CTL_ADDR, 8'h04);
    chk("nmi cleared", 24'h00_0000, {23'h0, nmi_request_o});
    twait("nmi after restart", cyc);
    wr(wdn_pkg::CTL_ADDR, 8'h04);
    $display("done restart");
  endtask

  task automatic t_irq();
    wr(wdn_pkg::STAT_ADDR, 8'h03);
    wr(wdn_pkg::MASK_ADDR, 8'h02);
    rchk("mask", wdn_pkg::MASK_ADDR, 8'h02);
    wr(wdn_pkg::CTL_ADDR, 8'h04);
    repeat (2) @(posedge clock_i);
    #1;
    chk("irq set", 24'h00_0001, {23'h0, irq_o});
    wr(wdn_pkg::STAT_ADDR, 8'h02);
    repeat (2) @(posedge clock_i);
    #1;
    chk("irq clear", 24'h00_0000, {23'h0, irq_o});
    wr(wdn_pkg::MASK_ADDR, 8'h00);
    wr(wdn_pkg::CTL_ADDR, 8'h04);
    repeat (2) @(posedge clock_i);
    #1;
    chk("irq masked", 24'h00_0000, {23'h0, irq_o});
    rchk("status", wdn_pkg::STAT_ADDR, 8'h02);
    rchk("unmapped", 24'h00_FF4F, 8'h00);
    $display("done irq");
  endtask

  task automatic t_sleep();
    int n;
    n = 0;
    // Request on the edge, look after it settles, so a zero hold shows as n of zero
    @(posedge clock_i);
    sleep_req <= 1'b1;
    #1;
    while (sleep !== 1'b1 && n < 200) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    chk("sleep held off", 24'h00_0001, {23'h0, n > 0 && n < 200});
    wr(wdn_pkg::CTL_ADDR, 8'h04);
    repeat (30 * TCLK) @(posedge clock_i);
    #1;
    chk("nmi in sleep", 24'h00_0000, {23'h0, nmi_request_o});
    rchk("flags", wdn_pkg::FLAG_ADDR, 8'h02);
    rchk("count", wdn_pkg::COUNT_ADDR, 8'h00);
    @(posedge clock_i);
    sleep_req <= 1'b0;
    twait("nmi after sleep", cyc);
    $display("done sleep");
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clock_i);
    reset_i <= 1'b0;
    rel = cyc;
    #1;
    t_reset();
    t_timeout();
    t_restart();
    t_irq();
    t_sleep();
    test_done();
  end
endmodule // wdn_watchdog_tb
